// >>> long_addr_skip_table_xor_ops_tb.sv
`timescale 1ns/1ps
`default_nettype none
module long_addr_skip_table_xor_ops_tb
  import ltx_pkg::*;
;
  logic ref_clk;
  logic rst_b;
  logic [2:0] regAddr;
  logic [15:0] regWrData;
  logic regWr;
  logic regRd;
  logic [15:0] regRdData;
  ltx_dm_req_t dmReq;
  logic [7:0] dmRdData;
  ltx_pm_req_t pmReq;
  logic [15:0] pmRdData;
  logic busy;
  logic skipTaken;
  logic done;
  logic [15:0] rd;
  int bad_count = 0;
  int num_checks = 0;
  int seed = 32'h1a34;

  ltx_exec_unit ltx_exec_unit_inst (.ref_clk(ref_clk), .rst_b(rst_b), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .dmReq(dmReq), .dmRdData(dmRdData), .pmReq(pmReq), .pmRdData(pmRdData),
    .busy(busy), .skipTaken(skipTaken), .done(done));
  ltx_mem_model ltx_mem_model_inst (.ref_clk(ref_clk), .rst_b(rst_b), .dmReq(dmReq),
    .dmRdData(dmRdData), .pmReq(pmReq), .pmRdData(pmRdData));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic regWrite(input logic [2:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask

  task automatic regRead(input logic [2:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1;
    d = regRdData;
  endtask

  // Counts cycles from the accept edge up to done, bounded
  // Busy must stand from the accept edge up to done and drop with done
  task automatic runInstr(input logic [15:0] cmd, output int n, output logic sk,
    output logic bOk);
    regWrite(REG_CMD, cmd);
    n = 0;
    sk = 1'b0;
    bOk = 1'b1;
    while (n < 20) begin
      @(posedge ref_clk);
      #1;
      n++;
      if (skipTaken === 1'b1) sk = 1'b1;
      if (busy !== (done !== 1'b1)) bOk = 1'b0;
      if (done === 1'b1) break;
    end
  endtask

  // Same fixed pattern that the memory model serves for every table word
  function automatic logic [15:0] tblWord(input logic [15:0] a);
    return {a[7:0] ^ 8'h3c, a[15:8] + a[7:0] + 8'h11};
  endfunction

  function automatic void predict(input logic [3:0] op, input logic [2:0] b,
    input logic [7:0] acc, mv, tpl, tph, th, input logic z,
    output logic [7:0] eAcc, eMem, eTpl, eTh, output logic eZ, eSk);
    logic [15:0] w;
    eAcc = acc;
    eMem = mv;
    eTpl = tpl;
    eTh = th;
    eZ = z;
    eSk = 1'b0;
    if (op == 4'h6 || op == 4'h7) eTpl = tpl + 8'h01;
    w = tblWord({(op == 4'h5 || op == 4'h7) ? LAST_PAGE : tph, eTpl});
    case (op)
      4'h0: eAcc = {mv[3:0], mv[7:4]};
      4'h1: eSk = (mv == 8'h00);
      4'h2: begin
        eAcc = mv;
        eSk = (mv == 8'h00);
      end
      4'h3: eSk = !mv[b];
      4'h4, 4'h5, 4'h6, 4'h7: begin
        eMem = w[7:0];
        eTh = w[15:8];
      end
      4'h8: begin
        eAcc = acc ^ mv;
        eZ = (eAcc == 8'h00);
      end
      4'h9: begin
        eMem = acc ^ mv;
        eZ = (eMem == 8'h00);
      end
      default: ;
    endcase
  endfunction

  task automatic end_sim();
    $display("Comparisons %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // About 24 cycles per test; the margin covers a hung instruction
  initial begin
    repeat (10000) @(posedge ref_clk);
    bad_count++;
    end_sim();
  end

  initial begin
    int n;
    logic sk, z, eZ, eSk, bOk;
    logic [7:0] acc, mv, tpl, tph, th, m, eAcc, eMem, eTpl, eTh;
    logic [3:0] op;
    logic [2:0] b;
    rst_b = 1'b0;
    regAddr = 3'h0;
    regWrData = 16'h0000;
    regWr = 1'b0;
    regRd = 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    regRead(REG_ACC, rd);
    chk("acc after reset", 16'h0000, rd);
    regWrite(REG_TBLHI, 16'h00ab);
    regRead(REG_TBLHI, rd);
    chk("table high result", 16'h0000, rd);
    regRead(3'h6, rd);
    chk("unmapped read", 16'h0000, rd);
    th = 8'h00;
    // First twenty walk every op twice with a wrapping pointer, a zero byte in the first ten
    for (int i = 0; i < 60; i++) begin
      op = (i < 20) ? 4'(i % 10) : 4'($random(seed));
      acc = 8'($random(seed));
      mv = (i < 10) ? 8'h00 : 8'($random(seed));
      if (i == 18 || i == 19) acc = mv;
      tpl = (i < 20) ? 8'hff : 8'($random(seed));
      tph = 8'($random(seed));
      m = 8'($random(seed));
      b = 3'($random(seed));
      z = 1'($random(seed));
      regWrite(REG_ACC, {8'h00, acc});
      regWrite(REG_STATUS, {15'h0000, z});
      regWrite(REG_TPLOW, {8'h00, tpl});
      regWrite(REG_TPHIGH, {8'h00, tph});
      ltx_mem_model_inst.dmem[m] = mv;
      predict(op, b, acc, mv, tpl, tph, th, z, eAcc, eMem, eTpl, eTh, eZ, eSk);
      runInstr({m, 1'b0, b, op}, n, sk, bOk);
      chk("cycles to done", eSk ? 16'h0004 : 16'h0002, 16'(n));
      chk("busy level", 16'h0001, {15'h0000, bOk});
      chk("skip pulse", {15'h0000, eSk}, {15'h0000, sk});
      regRead(REG_ACC, rd);
      chk("acc", {8'h00, eAcc}, rd);
      regRead(REG_STATUS, rd);
      chk("status", {10'h000, eSk ? 2'h3 : 2'h1, 2'h0, eSk, eZ}, rd & 16'h0033);
      regRead(REG_TBLHI, rd);
      chk("table high result", {8'h00, eTh}, rd);
      regRead(REG_TPLOW, rd);
      chk("table pointer low", {8'h00, eTpl}, rd);
      regRead(REG_TPHIGH, rd);
      chk("table pointer high", {8'h00, tph}, rd);
      chk("memory byte", {8'h00, eMem}, {8'h00, ltx_mem_model_inst.dmem[m]});
      th = eTh;
      $display("Test %0d op %0h finished", i, op);
    end
    end_sim();
  end
endmodule
`default_nettype wire

// >>> ltx_exec_unit.sv
// Overview of operation
// - Nibble swap loads ACC with swapped memory nibbles; memory and flags untouched.
// - Skip-on-null-byte rewrites the byte unchanged and skips when it is zero.
// - A taken skip adds a dummy fetch, three instruction cycles in all.
// - Skip-with-move copies the byte into ACC and skips on zero, no flags.
// - Bit test skips when the chosen bit is zero, else continues.
// - Given-page table read: word at high:low pointer, low to memory, high to result.
// - Final-page table read uses only low pointer on the last page.
// - Given-page preincrement read bumps low pointer, then reads with new pointer.
// - Final-page preincrement read bumps low pointer, then reads last page.
// - XOR to ACC stores ACC xor memory in ACC, only zero flag changes.
// - XOR to memory stores ACC xor memory in memory, only zero flag changes.
`timescale 1ns/1ps
`default_nettype none
module ltx_exec_unit
  import ltx_pkg::*;
(
  input wire logic ref_clk, // Core clock, 125 MHz
  input wire logic rst_b, // Asynchronous reset, active low
  input wire logic [2:0] regAddr, // Register index
  input wire logic [15:0] regWrData, // Register write data
  input wire logic regWr, // Register write strobe
  input wire logic regRd, // Register read strobe
  output logic [15:0] regRdData, // Read data, cycle after strobe
  output ltx_dm_req_t dmReq, // Data memory request
  input wire logic [7:0] dmRdData, // Data memory read data, cycle after rdEn
  output ltx_pm_req_t pmReq, // Program memory request
  input wire logic [15:0] pmRdData, // Program word, cycle after rdEn
  output logic busy, // Instruction in progress
  output logic skipTaken, // Pulse: the following instruction is skipped
  output logic done // Pulse: instruction finished
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic isTable(input ltx_op_t op);
    isTable = (op == OP_TABLE_GIVEN) || (op == OP_TABLE_FINAL) ||
              (op == OP_TABLE_GIVEN_INC) || (op == OP_TABLE_FINAL_INC);
  endfunction

  function automatic logic isPreInc(input ltx_op_t op);
    isPreInc = (op == OP_TABLE_GIVEN_INC) || (op == OP_TABLE_FINAL_INC);
  endfunction

  function automatic logic isFinalPage(input ltx_op_t op);
    isFinalPage = (op == OP_TABLE_FINAL) || (op == OP_TABLE_FINAL_INC);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ltx_state_t state_ff, nxt_state;
  ltx_cmd_t cmd_ff, nxt_cmd;
  logic [7:0] acc_ff, nxt_acc;
  logic zero_ff, nxt_zero;
  logic [7:0] tpLow_ff, nxt_tpLow;
  logic [7:0] tpHigh_ff, nxt_tpHigh;
  logic [7:0] tblHi_ff, nxt_tblHi;
  logic lastSkip_ff, nxt_lastSkip;
  logic [1:0] cycles_ff, nxt_cycles;
  ltx_dm_req_t dmReq_ff, nxt_dmReq;
  ltx_pm_req_t pmReq_ff, nxt_pmReq;
  logic [15:0] rdData_ff, nxt_rdData;
  logic skipTaken_ff, nxt_skipTaken;
  logic done_ff, nxt_done;
  logic busy_ff, nxt_busy;

  ltx_cmd_t newCmd;
  logic cmdAccept;
  logic swWrite;
  logic skipNow;
  logic [7:0] xorVal;
  logic [7:0] tpLowNew;

  assign newCmd = ltx_cmd_t'({regWrData[CMD_ADDR_POS +: 8], regWrData[CMD_BIT_POS +: 3],
                              regWrData[CMD_OP_POS +: 4]});
  assign cmdAccept = regWr && (regAddr == REG_CMD) && (state_ff == ST_IDLE);
  // Software may not disturb operands while an instruction is in flight
  assign swWrite = regWr && (state_ff == ST_IDLE);
  assign xorVal = acc_ff ^ dmRdData;
  assign tpLowNew = isPreInc(newCmd.op) ? tpLow_ff + TP_STEP : tpLow_ff;

  // ----------------------------------------------------------------
  // Execution sequencer
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_cmd = cmd_ff;
    nxt_acc = acc_ff;
    nxt_zero = zero_ff;
    nxt_tpLow = tpLow_ff;
    nxt_tpHigh = tpHigh_ff;
    nxt_tblHi = tblHi_ff;
    nxt_lastSkip = lastSkip_ff;
    nxt_cycles = cycles_ff;
    nxt_dmReq = '0;
    nxt_pmReq = '0;
    nxt_skipTaken = 1'b0;
    nxt_done = 1'b0;
    skipNow = 1'b0;
    unique case (state_ff)
      ST_IDLE: begin
        if (swWrite && regAddr == REG_ACC) begin
          nxt_acc = regWrData[7:0];
        end
        if (swWrite && regAddr == REG_STATUS) begin
          nxt_zero = regWrData[ST_ZERO_POS];
        end
        if (swWrite && regAddr == REG_TPLOW) begin
          nxt_tpLow = regWrData[7:0];
        end
        if (swWrite && regAddr == REG_TPHIGH) begin
          nxt_tpHigh = regWrData[7:0];
        end
        if (cmdAccept) begin
          nxt_cmd = newCmd;
          nxt_state = ST_FETCH;
          nxt_dmReq.rdEn = ~isTable(newCmd.op);
          nxt_dmReq.addr = newCmd.memAddr;
          nxt_tpLow = tpLowNew;
          nxt_pmReq.rdEn = isTable(newCmd.op);
          // Final page ignores the high pointer entirely
          nxt_pmReq.addr = isFinalPage(newCmd.op) ? {LAST_PAGE, tpLowNew}
                                                  : {tpHigh_ff, tpLowNew};
        end
      end
      ST_FETCH: begin
        nxt_state = ST_EXEC;
      end
      ST_EXEC: begin
        nxt_dmReq.addr = cmd_ff.memAddr;
        unique case (cmd_ff.op)
          OP_NIBBLE_SWAP: begin
            nxt_acc = {dmRdData[3:0], dmRdData[7:4]};
          end
          OP_SKIP_NULL: begin
            nxt_dmReq.wrEn = 1'b1;
            nxt_dmReq.wdata = dmRdData;
            skipNow = (dmRdData == 8'h00);
          end
          OP_SKIP_NULL_MOVE: begin
            nxt_acc = dmRdData;
            skipNow = (dmRdData == 8'h00);
          end
          OP_SKIP_BIT_NULL: begin
            skipNow = ~dmRdData[cmd_ff.bitSel];
          end
          OP_TABLE_GIVEN, OP_TABLE_FINAL, OP_TABLE_GIVEN_INC, OP_TABLE_FINAL_INC: begin
            nxt_dmReq.wrEn = 1'b1;
            nxt_dmReq.wdata = pmRdData[7:0];
            nxt_tblHi = pmRdData[15:8];
          end
          OP_XOR_ACC: begin
            nxt_acc = xorVal;
            nxt_zero = (xorVal == 8'h00);
          end
          OP_XOR_MEM: begin
            nxt_dmReq.wrEn = 1'b1;
            nxt_dmReq.wdata = xorVal;
            nxt_zero = (xorVal == 8'h00);
          end
          default: begin
            // Unassigned codes complete as a plain no-op
          end
        endcase
        nxt_lastSkip = skipNow;
        nxt_skipTaken = skipNow;
        nxt_cycles = skipNow ? CYC_SKIP : CYC_NORMAL;
        nxt_state = skipNow ? ST_SKIP : ST_IDLE;
        nxt_done = ~skipNow;
      end
      ST_SKIP: begin
        nxt_state = ST_DUMMY;
      end
      ST_DUMMY: begin
        // Dummy fetch replaces the skipped instruction
        nxt_state = ST_IDLE;
        nxt_done = 1'b1;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    nxt_busy = (nxt_state != ST_IDLE);
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= ST_IDLE;
      cmd_ff <= '0;
      acc_ff <= ACC_RST;
      zero_ff <= 1'b0;
      tpLow_ff <= TPLOW_RST;
      tpHigh_ff <= TPHIGH_RST;
      tblHi_ff <= TBLHI_RST;
      lastSkip_ff <= 1'b0;
      cycles_ff <= 2'h0;
      dmReq_ff <= '0;
      pmReq_ff <= '0;
      skipTaken_ff <= 1'b0;
      done_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cmd_ff <= nxt_cmd;
      acc_ff <= nxt_acc;
      zero_ff <= nxt_zero;
      tpLow_ff <= nxt_tpLow;
      tpHigh_ff <= nxt_tpHigh;
      tblHi_ff <= nxt_tblHi;
      lastSkip_ff <= nxt_lastSkip;
      cycles_ff <= nxt_cycles;
      dmReq_ff <= nxt_dmReq;
      pmReq_ff <= nxt_pmReq;
      skipTaken_ff <= nxt_skipTaken;
      done_ff <= nxt_done;
      busy_ff <= nxt_busy;
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  always_comb begin
    nxt_rdData = 16'h0000;
    if (regRd) begin
      unique case (regAddr)
        REG_ACC: nxt_rdData = {8'h00, acc_ff};
        REG_STATUS: begin
          nxt_rdData[ST_ZERO_POS] = zero_ff;
          nxt_rdData[ST_SKIP_POS] = lastSkip_ff;
          nxt_rdData[ST_BUSY_POS] = busy_ff;
          nxt_rdData[ST_CYC_POS +: 2] = cycles_ff;
        end
        REG_TPLOW: nxt_rdData = {8'h00, tpLow_ff};
        REG_TPHIGH: nxt_rdData = {8'h00, tpHigh_ff};
        REG_TBLHI: nxt_rdData = {8'h00, tblHi_ff};
        REG_CMD: nxt_rdData = {cmd_ff.memAddr, 1'b0, cmd_ff.bitSel, cmd_ff.op};
        default: nxt_rdData = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdData_ff <= 16'h0000;
    end else begin
      rdData_ff <= nxt_rdData;
    end
  end

  assign regRdData = rdData_ff;
  assign dmReq = dmReq_ff;
  assign pmReq = pmReq_ff;
  assign busy = busy_ff;
  assign skipTaken = skipTaken_ff;
  assign done = done_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  sequence seqExecOp(ltx_op_t o);
    (state_ff == ST_EXEC) && (cmd_ff.op == o);
  endsequence

  sequence seqSkipTail;
    (state_ff == ST_SKIP) && !done_ff ##1 (state_ff == ST_DUMMY) && !done_ff
      ##1 (state_ff == ST_IDLE) && done_ff;
  endsequence

  chk_swap_nibbles: assert property (
    seqExecOp(OP_NIBBLE_SWAP) |=> acc_ff == {$past(dmRdData[3:0]), $past(dmRdData[7:4])}
      && $stable(zero_ff) && !dmReq_ff.wrEn)
    else $error("nibble swap result wrong");

  chk_null_rewrite: assert property (
    seqExecOp(OP_SKIP_NULL) |=> dmReq_ff.wrEn && dmReq_ff.wdata == $past(dmRdData)
      && skipTaken_ff == ($past(dmRdData) == 8'h00))
    else $error("null byte skip or rewrite wrong");

  chk_skip_three_cycles: assert property (
    (state_ff == ST_EXEC) && skipNow |=> skipTaken_ff && busy_ff ##0 seqSkipTail)
    else $error("taken skip does not last three cycles");

  chk_skip_move: assert property (
    seqExecOp(OP_SKIP_NULL_MOVE) |=> acc_ff == $past(dmRdData) && $stable(zero_ff)
      && skipTaken_ff == ($past(dmRdData) == 8'h00))
    else $error("skip with move wrong");

  chk_bit_skip: assert property (
    seqExecOp(OP_SKIP_BIT_NULL) |=> skipTaken_ff == !$past(dmRdData[cmd_ff.bitSel])
      && (done_ff != skipTaken_ff))
    else $error("bit test skip wrong");

  chk_given_page_read: assert property (
    cmdAccept && isTable(newCmd.op) && !isFinalPage(newCmd.op)
      |=> pmReq_ff.rdEn && pmReq_ff.addr == {tpHigh_ff, tpLow_ff}
      ##2 tblHi_ff == $past(pmRdData[15:8]) && dmReq_ff.wdata == $past(pmRdData[7:0]))
    else $error("given page table read wrong");

  chk_final_page_read: assert property (
    cmdAccept && isFinalPage(newCmd.op)
      |=> pmReq_ff.rdEn && pmReq_ff.addr == {LAST_PAGE, tpLow_ff}
      ##2 dmReq_ff.wrEn && tblHi_ff == $past(pmRdData[15:8]))
    else $error("final page table read wrong");

  chk_preinc_pointer: assert property (
    cmdAccept && isPreInc(newCmd.op) |=> tpLow_ff == $past(tpLow_ff) + TP_STEP
      && pmReq_ff.addr[7:0] == tpLow_ff)
    else $error("pointer not incremented before read");

  chk_preinc_wrap: assert property (
    cmdAccept && isPreInc(newCmd.op) && tpLow_ff == 8'hff
      |=> tpLow_ff == 8'h00 && $stable(tpHigh_ff))
    else $error("pointer increment carried or failed to wrap");

  chk_xor_acc: assert property (
    seqExecOp(OP_XOR_ACC) |=> acc_ff == ($past(acc_ff) ^ $past(dmRdData))
      && zero_ff == (acc_ff == 8'h00) && !dmReq_ff.wrEn)
    else $error("xor to accumulator wrong");

  chk_xor_mem: assert property (
    seqExecOp(OP_XOR_MEM) |=> dmReq_ff.wrEn && dmReq_ff.wdata == (acc_ff ^ $past(dmRdData))
      && zero_ff == (dmReq_ff.wdata == 8'h00) && $stable(acc_ff))
    else $error("xor to memory wrong");

endmodule
`default_nettype wire

// >>> ltx_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Data and program memory on the far side of the core
// ----------------------------------------------------------------
module ltx_mem_model
  import ltx_pkg::*;
(
  input wire logic ref_clk, // Core clock
  input wire logic rst_b, // Asynchronous reset, active low
  input wire ltx_dm_req_t dmReq, // Data memory request
  output logic [7:0] dmRdData, // Data byte, cycle after read
  input wire ltx_pm_req_t pmReq, // Program memory request
  output logic [15:0] pmRdData // Program word, cycle after read
);
  logic [7:0] dmem [256];
  logic [7:0] dmLast;
  logic [15:0] pmLast;
  logic dmValid;
  logic pmValid;

  // Fixed pattern so the bench can predict every table word
  function automatic logic [15:0] pmWord(input logic [15:0] a);
    return {a[7:0] ^ 8'h3c, a[15:8] + a[7:0] + 8'h11};
  endfunction

  // Plain always: the bench preloads bytes straight into the array
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      dmValid <= 1'b0;
      pmValid <= 1'b0;
      dmLast <= 8'h00;
      pmLast <= 16'h0000;
    end else begin
      dmValid <= dmReq.rdEn;
      pmValid <= pmReq.rdEn;
      if (dmReq.rdEn) begin
        dmLast <= dmem[dmReq.addr];
      end
      if (pmReq.rdEn) begin
        pmLast <= pmWord(pmReq.addr);
      end
      if (dmReq.wrEn) begin
        dmem[dmReq.addr] <= dmReq.wdata;
      end
    end
  end

  // Outside the answer cycle show the inverse, so a late sample fails
  assign dmRdData = dmValid ? dmLast : ~dmLast;
  assign pmRdData = pmValid ? pmLast : ~pmLast;
endmodule
`default_nettype wire

// >>> ltx_pkg.sv
package ltx_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PADDR_W = 16;
  localparam int unsigned PWORD_W = 16;
  localparam int unsigned REG_AW = 3;

  // ----------------------------------------------------------------
  // Register indices on the plain register port
  // ----------------------------------------------------------------
  localparam logic [2:0] REG_ACC = 3'h0;
  localparam logic [2:0] REG_STATUS = 3'h1;
  localparam logic [2:0] REG_TPLOW = 3'h2;
  localparam logic [2:0] REG_TPHIGH = 3'h3;
  localparam logic [2:0] REG_TBLHI = 3'h4;
  localparam logic [2:0] REG_CMD = 3'h5;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned ST_ZERO_POS = 0;
  localparam int unsigned ST_SKIP_POS = 1;
  localparam int unsigned ST_BUSY_POS = 2;
  localparam int unsigned ST_CYC_POS = 4;
  localparam int unsigned CMD_OP_POS = 0;
  localparam int unsigned CMD_BIT_POS = 4;
  localparam int unsigned CMD_ADDR_POS = 8;

  // ----------------------------------------------------------------
  // Reset values and constants
  // ----------------------------------------------------------------
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] TPLOW_RST = 8'h00;
  localparam logic [7:0] TPHIGH_RST = 8'h00;
  localparam logic [7:0] TBLHI_RST = 8'h00;
  localparam logic [7:0] LAST_PAGE = 8'hff;
  localparam logic [7:0] TP_STEP = 8'h01;
  localparam logic [1:0] CYC_NORMAL = 2'h1;
  localparam logic [1:0] CYC_SKIP = 2'h3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NIBBLE_SWAP = 4'h0,
    OP_SKIP_NULL = 4'h1,
    OP_SKIP_NULL_MOVE = 4'h2,
    OP_SKIP_BIT_NULL = 4'h3,
    OP_TABLE_GIVEN = 4'h4,
    OP_TABLE_FINAL = 4'h5,
    OP_TABLE_GIVEN_INC = 4'h6,
    OP_TABLE_FINAL_INC = 4'h7,
    OP_XOR_ACC = 4'h8,
    OP_XOR_MEM = 4'h9
  } ltx_op_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_FETCH = 5'b00010,
    ST_EXEC = 5'b00100,
    ST_SKIP = 5'b01000,
    ST_DUMMY = 5'b10000
  } ltx_state_t;

  typedef struct packed {
    logic [7:0] memAddr;
    logic [2:0] bitSel;
    ltx_op_t op;
  } ltx_cmd_t;

  typedef struct packed {
    logic rdEn;
    logic wrEn;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ltx_dm_req_t;

  typedef struct packed {
    logic rdEn;
    logic [15:0] addr;
  } ltx_pm_req_t;

endpackage
